// file: logic/gated_sixteen_bit_timer.sv
/*
 * Gated 16-bit timer/counter with prescaler, gate polarity, toggle and
 * single-pulse functions and buffered 16-bit access.
 * Assumes all pins synchronous to i_clk and a byte-wide register port whose
 * read data stand in the cycle after the read strobe.
 */
// Strobed register access and the address map are this design's own decisions.
// Function
// RL1: Source field picks instruction clock, system clock, or pin/oscillator per enable bit.
// RL2: Count pin rising edges count only after first falling edge once set up.
// RL3: Prescale field divides selected clock by 1, 2, 4 or 8.
// RL4: Sync bypass bit skips pin synchroniser for external source; ignored otherwise.
// RL5: Oscillator enable bit turns secondary oscillator on as timer source.
// RL6: Count only while on; gate enable chooses gated or free counting.
// RL7: Gate polarity one counts while gate high, zero while gate low.
// RL8: Toggle mode flips gate flip-flop on rising gate edges; otherwise held clear.
// RL9: Single-pulse bit hands gate control to the single-pulse logic.
// RL10: Acquire status reads one while armed and waiting, zero otherwise.
// RL11: Clearing single-pulse mode clears the acquire status bit.
// RL12: Gate state bit shows applied gate level regardless of gate enable.
// RL13: Gate source field picks pin, period match, comparator one or two.
// RL14: Watchdog oscillator request follows gate enable regardless of on bit.
// RL15: Software should write gate control before timer control.
// RL16: Software should not use system clock with capture or compare.
// RL17: Wide access bit gives 16-bit access; otherwise two independent bytes.
// RL18: In wide mode low byte read copies live high byte into buffer.
// RL19: In wide mode high writes go to buffer, loaded on low write.
// RL20: Low byte write clears prescaler; high byte write leaves it.
// RL21: Counter is 16 bits as readable and writable high and low bytes.
// RL22: Counter wraps from maximum to zero and latches an overflow flag.
// RL23: Falling edge of gate state sets gate event flag even ungated.
// RL24: Single-pulse acquisition ends at trailing edge; no counting until rearmed.
// RL25: Reset clears control registers, counter and prescaler.
module gated_sixteen_bit_timer (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_count_pin,
	input wire logic i_secondary_oscillator,
	input wire logic i_gate_pin,
	input wire logic i_period_match,
	input wire logic i_comp1,
	input wire logic i_comp2,
	output logic [7:0] o_rdata,
	output logic o_overflow_flag,
	output logic o_gate_event_flag,
	output logic o_osc_enable,
	output logic o_watchdog_osc_on
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] timer_control_reg;
	logic [7:0] gate_control_reg;
	logic [15:0] count_reg;
	logic [7:0] high_buffer_reg;
	logic [2:0] prescale_reg;
	logic [1:0] instr_div_reg;
	logic [1:0] ext_sync_reg;
	logic ext_prev_reg;
	logic ext_armed_reg;
	logic gate_src_prev_reg;
	logic toggle_reg;
	logic acquire_reg;
	logic pulse_seen_reg;
	logic gate_val_reg;
	logic overflow_reg;
	logic gate_event_reg;

	// Field views
	logic [1:0] clock_source_select, prescale_select, gate_source_select;
	logic secondary_osc_enable, ext_clock_sync_bypass, wide_access_mode, timer_on, gate_enable;
	logic gate_polarity, gate_toggle_mode, gate_single_pulse_mode;

	assign clock_source_select = timer_control_reg[gated_timer_pkg::TC_SOURCE_LSB +: 2];
	assign prescale_select = timer_control_reg[gated_timer_pkg::TC_PRESCALE_LSB +: 2];
	assign secondary_osc_enable = timer_control_reg[gated_timer_pkg::TC_OSC_ENABLE];
	assign ext_clock_sync_bypass = timer_control_reg[gated_timer_pkg::TC_SYNC_BYPASS];
	assign wide_access_mode = timer_control_reg[gated_timer_pkg::TC_WIDE_ACCESS];
	assign timer_on = timer_control_reg[gated_timer_pkg::TC_TIMER_ON];
	assign gate_enable = gate_control_reg[gated_timer_pkg::GC_ENABLE];
	assign gate_polarity = gate_control_reg[gated_timer_pkg::GC_POLARITY];
	assign gate_toggle_mode = gate_control_reg[gated_timer_pkg::GC_TOGGLE];
	assign gate_single_pulse_mode = gate_control_reg[gated_timer_pkg::GC_SINGLE_PULSE];
	assign gate_source_select = gate_control_reg[gated_timer_pkg::GC_SOURCE_LSB +: 2];

	// Register decode strobes
	logic wr_low, wr_high, wr_tc, wr_gc, wr_flags, rd_low;
	assign wr_low = i_wr && (i_addr == gated_timer_pkg::ADDR_COUNT_LOW);
	assign wr_high = i_wr && (i_addr == gated_timer_pkg::ADDR_COUNT_HIGH);
	assign wr_tc = i_wr && (i_addr == gated_timer_pkg::ADDR_TIMER_CONTROL);
	assign wr_gc = i_wr && (i_addr == gated_timer_pkg::ADDR_GATE_CONTROL);
	assign wr_flags = i_wr && (i_addr == gated_timer_pkg::ADDR_FLAGS);
	assign rd_low = i_rd && (i_addr == gated_timer_pkg::ADDR_COUNT_LOW);

	// ****************************************
	// Clock source and prescaler
	// ****************************************
	logic ext_raw, ext_level, ext_rise, src_tick, pre_tick;
	logic [2:0] prescale_mask;

	// Pin or oscillator, synchronised unless bypassed
	assign ext_raw = secondary_osc_enable ? i_secondary_oscillator : i_count_pin; // RL1 RL5
	assign ext_level = ext_clock_sync_bypass ? ext_raw : ext_sync_reg[1]; // RL4

	// Synchroniser for the external source
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ext_sync_reg <= 2'h0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[0], ext_raw};
		end
	end

	// First falling edge arms the external counter
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ext_prev_reg <= 1'b0;
			ext_armed_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_level;
			if (wr_tc || clock_source_select != gated_timer_pkg::SRC_EXTERNAL) begin
				ext_armed_reg <= 1'b0; // RL2
			end else if (ext_prev_reg && !ext_level) begin
				ext_armed_reg <= 1'b1; // RL2
			end
		end
	end

	assign ext_rise = ext_armed_reg && !ext_prev_reg && ext_level; // RL2

	// Instruction clock is one system tick in four
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			instr_div_reg <= 2'h0;
		end else begin
			instr_div_reg <= instr_div_reg + 2'h1;
		end
	end

	// Selected input tick
	always_comb begin
		case (clock_source_select)
			gated_timer_pkg::SRC_INSTR_CLOCK: src_tick = (instr_div_reg == gated_timer_pkg::INSTR_DIVIDE_LAST); // RL1
			gated_timer_pkg::SRC_SYSTEM_CLOCK: src_tick = 1'b1; // RL1
			gated_timer_pkg::SRC_EXTERNAL: src_tick = ext_rise; // RL1
			default: src_tick = 1'b0;
		endcase
	end

	// Divide ratio mask 1, 2, 4, 8
	always_comb begin
		case (prescale_select)
			2'h0: prescale_mask = 3'h0;
			2'h1: prescale_mask = 3'h1;
			2'h2: prescale_mask = 3'h3;
			default: prescale_mask = 3'h7;
		endcase
	end

	logic gate_open, count_tick;
	assign pre_tick = src_tick && ((prescale_reg & prescale_mask) == prescale_mask); // RL3
	assign count_tick = timer_on && pre_tick && (!gate_enable || gate_open); // RL6

	// Prescaler counter, cleared by low byte write
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prescale_reg <= gated_timer_pkg::PRESCALE_RESET; // RL25
		end else if (wr_low) begin
			prescale_reg <= gated_timer_pkg::PRESCALE_RESET; // RL20
		end else if (timer_on && src_tick) begin
			prescale_reg <= prescale_reg + 3'h1; // RL3
		end
	end

	// ****************************************
	// Gate path
	// ****************************************
	logic gate_src, gate_pol, gate_tgl, gate_level;

	// Source selection
	always_comb begin
		case (gate_source_select)
			gated_timer_pkg::GSRC_PIN: gate_src = i_gate_pin; // RL13
			gated_timer_pkg::GSRC_PERIOD_MATCH: gate_src = i_period_match; // RL13
			gated_timer_pkg::GSRC_COMP1: gate_src = i_comp1; // RL13
			gated_timer_pkg::GSRC_COMP2: gate_src = i_comp2; // RL13
			default: gate_src = 1'b0;
		endcase
	end

	assign gate_pol = gate_polarity ? gate_src : !gate_src; // RL7
	assign gate_tgl = gate_toggle_mode ? toggle_reg : gate_pol;
	assign gate_level = gate_single_pulse_mode ? (gate_tgl && acquire_reg) : gate_tgl; // RL9
	assign gate_open = gate_val_reg;

	// Toggle flip-flop on rising active gate edges
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gate_src_prev_reg <= 1'b0;
			toggle_reg <= 1'b0;
		end else begin
			gate_src_prev_reg <= gate_pol;
			if (!gate_toggle_mode) begin
				toggle_reg <= 1'b0; // RL8
			end else if (gate_pol && !gate_src_prev_reg) begin
				toggle_reg <= !toggle_reg; // RL8
			end
		end
	end

	// Single-pulse acquisition status
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			acquire_reg <= 1'b0;
			pulse_seen_reg <= 1'b0;
		end else if (!gate_single_pulse_mode || (wr_gc && !i_wdata[gated_timer_pkg::GC_SINGLE_PULSE])) begin
			acquire_reg <= 1'b0; // RL11
			pulse_seen_reg <= 1'b0;
		end else if (wr_gc && i_wdata[gated_timer_pkg::GC_ACQUIRE_STATUS]) begin
			acquire_reg <= 1'b1; // RL10
			pulse_seen_reg <= 1'b0;
		end else if (acquire_reg && gate_tgl) begin
			pulse_seen_reg <= 1'b1;
		end else if (acquire_reg && pulse_seen_reg && !gate_tgl) begin
			acquire_reg <= 1'b0; // RL24
		end
	end

	// Gate state and gate event flag
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gate_val_reg <= 1'b0;
			gate_event_reg <= 1'b0;
		end else begin
			gate_val_reg <= gate_level; // RL12
			if (gate_val_reg && !gate_level) begin
				gate_event_reg <= 1'b1; // RL23
			end else if (wr_flags && i_wdata[gated_timer_pkg::FL_GATE_EVENT]) begin
				gate_event_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			timer_control_reg <= gated_timer_pkg::TIMER_CONTROL_RESET; // RL25
			gate_control_reg <= gated_timer_pkg::GATE_CONTROL_RESET; // RL25
		end else begin
			if (wr_tc) begin
				timer_control_reg <= i_wdata;
			end
			if (wr_gc) begin
				gate_control_reg <= i_wdata;
			end
		end
	end

	// ****************************************
	// Counter and high byte buffer
	// ****************************************
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count_reg <= gated_timer_pkg::COUNT_RESET; // RL25
		end else if (wr_low) begin
			count_reg <= {wide_access_mode ? high_buffer_reg : count_reg[15:8], i_wdata}; // RL19 RL21
		end else if (wr_high && !wide_access_mode) begin
			count_reg <= {i_wdata, count_reg[7:0]}; // RL17 RL21
		end else if (count_tick) begin
			count_reg <= count_reg + 16'h0001; // RL22
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			high_buffer_reg <= 8'h00;
		end else if (wr_high && wide_access_mode) begin
			high_buffer_reg <= i_wdata; // RL19
		end else if (rd_low && wide_access_mode) begin
			high_buffer_reg <= count_reg[15:8]; // RL18
		end
	end

	// Overflow flag, set wins over clear
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			overflow_reg <= 1'b0;
		end else if (count_tick && !wr_low && !(wr_high && !wide_access_mode)
			&& count_reg == gated_timer_pkg::COUNT_MAX) begin
			overflow_reg <= 1'b1; // RL22
		end else if (wr_flags && i_wdata[gated_timer_pkg::FL_OVERFLOW]) begin
			overflow_reg <= 1'b0;
		end
	end

	// ****************************************
	// Read port and outputs
	// ****************************************
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				gated_timer_pkg::ADDR_COUNT_LOW: o_rdata <= count_reg[7:0];
				gated_timer_pkg::ADDR_COUNT_HIGH: o_rdata <= wide_access_mode ? high_buffer_reg : count_reg[15:8];
				gated_timer_pkg::ADDR_TIMER_CONTROL: o_rdata <= timer_control_reg;
				gated_timer_pkg::ADDR_GATE_CONTROL: o_rdata <= {gate_control_reg[7:4], acquire_reg,
					gate_val_reg, gate_control_reg[1:0]}; // RL10 RL12
				gated_timer_pkg::ADDR_FLAGS: o_rdata <= {6'h00, gate_event_reg, overflow_reg};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Flags and oscillator requests
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_overflow_flag <= 1'b0;
			o_gate_event_flag <= 1'b0;
			o_osc_enable <= 1'b0;
			o_watchdog_osc_on <= 1'b0;
		end else begin
			o_overflow_flag <= overflow_reg;
			o_gate_event_flag <= gate_event_reg;
			o_osc_enable <= secondary_osc_enable; // RL5
			o_watchdog_osc_on <= gate_enable; // RL14
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_prescale_clear: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL20
		wr_low |=> prescale_reg == gated_timer_pkg::PRESCALE_RESET) else $error("prescaler not cleared");
	a_wrap_flag: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL22
		(count_tick && !i_wr && count_reg == gated_timer_pkg::COUNT_MAX) |=> (count_reg == 16'h0000 && overflow_reg))
		else $error("overflow wrap wrong");
	a_off_holds: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL6
		(!timer_on && !i_wr) |=> $stable(count_reg)) else $error("counted while off");
	a_spm_clear: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL11
		!gate_single_pulse_mode |=> !acquire_reg) else $error("acquire not cleared");
	a_toggle_clear: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL8
		!gate_toggle_mode |=> !toggle_reg) else $error("toggle not held");
	a_gate_event: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL23
		$fell(gate_val_reg) |-> gate_event_reg) else $error("gate event missed");
	a_wide_read: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL18
		(rd_low && wide_access_mode && !i_wr) |=> high_buffer_reg == $past(count_reg[15:8]))
		else $error("buffer not loaded");
	a_wide_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL19
		(wr_high && wide_access_mode) |=> $stable(count_reg[15:8]) || $past(count_tick))
		else $error("high written directly");
	a_wdt_osc: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL14
		##1 o_watchdog_osc_on == $past(gate_enable)) else $error("watchdog request wrong");
	c_overflow: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(overflow_reg));
	c_pulse_done: cover property (@(posedge i_clk) disable iff (!i_nrst) $fell(acquire_reg));
	c_ext_count: cover property (@(posedge i_clk) disable iff (!i_nrst) ext_rise && count_tick);

endmodule : gated_sixteen_bit_timer

// file: logic/gated_timer_pkg.sv
/*
 * Constants shared by the gated 16-bit timer: register offsets, field
 * positions, reset values and encodings of the clock and gate selections.
 * Assumes a plain byte-wide register port with one-cycle strobes.
 */
package gated_timer_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [2:0] ADDR_COUNT_LOW = 3'h0;
	localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
	localparam logic [2:0] ADDR_TIMER_CONTROL = 3'h2;
	localparam logic [2:0] ADDR_GATE_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_FLAGS = 3'h4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;

	// ****************************************
	// Timer control fields
	// ****************************************
	localparam int TC_TIMER_ON = 0;
	localparam int TC_WIDE_ACCESS = 1;
	localparam int TC_SYNC_BYPASS = 2;
	localparam int TC_OSC_ENABLE = 3;
	localparam int TC_PRESCALE_LSB = 4;
	localparam int TC_SOURCE_LSB = 6;

	// ****************************************
	// Gate control fields
	// ****************************************
	localparam int GC_SOURCE_LSB = 0;
	localparam int GC_CURRENT_STATE = 2;
	localparam int GC_ACQUIRE_STATUS = 3;
	localparam int GC_SINGLE_PULSE = 4;
	localparam int GC_TOGGLE = 5;
	localparam int GC_POLARITY = 6;
	localparam int GC_ENABLE = 7;

	// ****************************************
	// Flag register fields
	// ****************************************
	localparam int FL_OVERFLOW = 0;
	localparam int FL_GATE_EVENT = 1;

	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] SRC_INSTR_CLOCK = 2'h0;
	localparam logic [1:0] SRC_SYSTEM_CLOCK = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	localparam logic [1:0] GSRC_PIN = 2'h0;
	localparam logic [1:0] GSRC_PERIOD_MATCH = 2'h1;
	localparam logic [1:0] GSRC_COMP1 = 2'h2;
	localparam logic [1:0] GSRC_COMP2 = 2'h3;
	localparam logic [1:0] INSTR_DIVIDE_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;

endpackage : gated_timer_pkg

// file: test/gated_sixteen_bit_timer_bench.sv
/*
 * Self-checking bench for the gated timer: bus driver noting expected
 * read bytes in a queue, read monitor, far-side model.
 * Assumes the design package is compiled first and one 50 MHz clock.
 */
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("ERROR %0t: got %h expected %h", $time, (g), (e)); \
	end \
end
module gated_sixteen_bit_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] e; logic [7:0] m;} note_t;
	localparam int LIMIT = 10000;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic ext_run = 1'b0;
	logic cnt_pin, osc, g_pin, pm, c1, c2, o_overflow_flag, o_gate_event_flag, o_osc_enable, o_watchdog_osc_on;
	logic [7:0] o_rdata, last_rd, r;
	note_t notes[$];
	note_t mon_n;
	logic rd_pend = 1'b0;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;

	gated_sixteen_bit_timer u_gated_sixteen_bit_timer (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_count_pin(cnt_pin), .i_secondary_oscillator(osc),
		.i_gate_pin(g_pin), .i_period_match(pm), .i_comp1(c1), .i_comp2(c2), .o_rdata(o_rdata),
		.o_overflow_flag(o_overflow_flag), .o_gate_event_flag(o_gate_event_flag),
		.o_osc_enable(o_osc_enable), .o_watchdog_osc_on(o_watchdog_osc_on));
	timer_far_side u_timer_far_side (.i_clk(i_clk), .i_nrst(i_nrst), .i_ext_run(ext_run), .i_levels(lvl),
		.o_count_pin(cnt_pin), .o_secondary_oscillator(osc), .o_gate_pin(g_pin), .o_period_match(pm),
		.o_comp1(c1), .o_comp2(c2));

	// Clock
	always #10 i_clk = ~i_clk;

	// ****************************************
	// Bus tasks and closing report
	// ****************************************
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		note_t n;
		n.e = e;
		n.m = m;
		notes.push_back(n);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	task automatic pulse();
		lvl <= 4'h1;
		tick(6);
		lvl <= 4'h0;
		tick(6);
	endtask : pulse
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// Read monitor: oldest note against the byte after each read, and timeout
	always @(posedge i_clk) begin
		if (rd_pend) begin
			mon_n = notes.pop_front();
			`CHK(o_rdata & mon_n.m, mon_n.e & mon_n.m)
			last_rd = o_rdata;
		end
		rd_pend = i_rd;
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			wrap_up();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(17282));
		tick(10);
		i_nrst <= 1'b1;
		tick(2);
		// Reset values, then an unmapped address
		rd(gated_timer_pkg::ADDR_TIMER_CONTROL, gated_timer_pkg::TIMER_CONTROL_RESET, 8'hFF);
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, gated_timer_pkg::GATE_CONTROL_RESET, 8'hFB);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'hFF);
		rd(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h00, 8'hFF);
		wr(3'h5, 8'hFF);
		rd(3'h5, 8'h00, 8'hFF);
		// Control registers read back, timer kept off
		r = 8'($urandom());
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, r & 8'hFE);
		rd(gated_timer_pkg::ADDR_TIMER_CONTROL, r & 8'hFE, 8'hFF);
		`CHK(o_osc_enable, r[3])
		r = 8'($urandom());
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, r & 8'hE3);
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, r & 8'hE3, 8'hFB);
		`CHK(o_watchdog_osc_on, r[7])
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h00);
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		// Byte access, then buffered wide access
		wr(gated_timer_pkg::ADDR_COUNT_LOW, 8'hA5);
		wr(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h3C);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'hA5, 8'hFF);
		rd(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h3C, 8'hFF);
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h02);
		wr(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h77);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'hA5, 8'hFF);
		rd(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h3C, 8'hFF);
		wr(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h77);
		wr(gated_timer_pkg::ADDR_COUNT_LOW, 8'h11);
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rd(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h77, 8'hFF);
		// Instruction and system clock at every prescale over a 32-cycle window; no capture here
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 4; p++) begin
				wr(gated_timer_pkg::ADDR_TIMER_CONTROL, {s[1:0], p[1:0], 4'h1});
				rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00);
				tick(30);
				rd(gated_timer_pkg::ADDR_COUNT_LOW, last_rd + 8'(32 / ((s ? 1 : 4) << p)), 8'hFF);
			end
		end
		// Low write restarts the prescaler at a random phase
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h71);
		for (int k = 0; k < 6; k++) begin
			tick($urandom_range(7));
			wr(gated_timer_pkg::ADDR_COUNT_LOW, 8'h40);
			rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h40, 8'hFF);
		end
		// Rollover sets the sticky flag, write one clears it
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		wr(gated_timer_pkg::ADDR_FLAGS, 8'h03);
		wr(gated_timer_pkg::ADDR_COUNT_HIGH, 8'hFF);
		wr(gated_timer_pkg::ADDR_COUNT_LOW, 8'hFC);
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h41);
		tick(10);
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h40);
		`CHK(o_overflow_flag, 1'b1)
		rd(gated_timer_pkg::ADDR_COUNT_HIGH, 8'h00, 8'hFF);
		wr(gated_timer_pkg::ADDR_FLAGS, 8'h01);
		rd(gated_timer_pkg::ADDR_FLAGS, 8'h00, 8'h01);
		// Timer off holds even with the gate enabled
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h80);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00);
		tick(30);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, last_rd, 8'hFF);
		// Gated counting for each polarity; gate control written first
		for (int pol = 0; pol < 2; pol++) begin
			lvl <= 4'h0;
			wr(gated_timer_pkg::ADDR_GATE_CONTROL, {1'b1, pol[0], 6'h00});
			wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h41);
			for (int lv = 0; lv < 2; lv++) begin
				lvl <= 4'(lv);
				tick(4);
				rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00);
				tick(30);
				rd(gated_timer_pkg::ADDR_COUNT_LOW, last_rd + ((pol == lv) ? 8'h20 : 8'h00), 8'hFF);
			end
		end
		// Period-match pulses gate two counts per window; gate ignored when off
		for (int g = 0; g < 2; g++) begin
			lvl <= 4'h2;
			wr(gated_timer_pkg::ADDR_GATE_CONTROL, g ? 8'h41 : 8'hC1);
			tick(4);
			rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00);
			tick(30);
			rd(gated_timer_pkg::ADDR_COUNT_LOW, last_rd + (g ? 8'h20 : 8'h02), 8'hFF);
		end
		// Gate state for each level source, gate disabled
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		for (int g = 0; g < 4; g++) begin
			if (g == 1) continue;
			lvl <= 4'h1 << g;
			wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h40 | 8'(g));
			rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h04, 8'h04);
			lvl <= ~(4'h1 << g) & 4'hD;
			tick(3);
			rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h00, 8'h04);
		end
		// Falling gate state sets the event flag while ungated
		lvl <= 4'h0;
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h40);
		wr(gated_timer_pkg::ADDR_FLAGS, 8'h03);
		pulse();
		`CHK(o_gate_event_flag, 1'b1)
		wr(gated_timer_pkg::ADDR_FLAGS, 8'h02);
		rd(gated_timer_pkg::ADDR_FLAGS, 8'h00, 8'h02);
		// Toggle flip-flop changes on each rising gate edge
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h60);
		pulse();
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h04, 8'h04);
		pulse();
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h00, 8'h04);
		// Single pulse: armed, done after the pulse, then no more counting
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'hD0);
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'hD8);
		wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h41);
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h08, 8'h08);
		pulse();
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h00, 8'h08);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00);
		pulse();
		rd(gated_timer_pkg::ADDR_COUNT_LOW, last_rd, 8'hFF);
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'hD8);
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'hC8);
		rd(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h00, 8'h08);
		// External pin: first rise before any fall is not counted
		wr(gated_timer_pkg::ADDR_GATE_CONTROL, 8'h00);
		for (int b = 0; b < 2; b++) begin
			wr(gated_timer_pkg::ADDR_TIMER_CONTROL, 8'h81 | 8'(b << 2));
			tick(4);
			rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00);
			ext_run <= 1'b1;
			tick(64);
			ext_run <= 1'b0;
			tick(8);
			rd(gated_timer_pkg::ADDR_COUNT_LOW, last_rd + 8'h07, 8'hFF);
		end
		// Reset in mid-run returns control, count and flags to zero
		i_nrst <= 1'b0;
		tick(2);
		i_nrst <= 1'b1;
		tick(2);
		rd(gated_timer_pkg::ADDR_TIMER_CONTROL, gated_timer_pkg::TIMER_CONTROL_RESET, 8'hFF);
		rd(gated_timer_pkg::ADDR_COUNT_LOW, 8'h00, 8'hFF);
		rd(gated_timer_pkg::ADDR_FLAGS, 8'h00, 8'hFF);
		tick(2);
		wrap_up();
	end
endmodule : gated_sixteen_bit_timer_bench

// file: test/timer_far_side.sv
/*
 * Far-side model of the gated timer: count pin bursts, free-running
 * oscillator, gate pin, comparator levels and a period-match pulse.
 * Assumes the bench commands levels and bursts on the timer clock.
 */
module timer_far_side (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ext_run,
	input wire logic [3:0] i_levels,
	output logic o_count_pin,
	output logic o_secondary_oscillator,
	output logic o_gate_pin,
	output logic o_period_match,
	output logic o_comp1,
	output logic o_comp2
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_reg;
	logic [3:0] match_reg;

	// Count pin toggles every fourth edge in a burst, rests low between
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_reg <= 2'h0;
			o_count_pin <= 1'b0;
		end else if (!i_ext_run) begin
			phase_reg <= 2'h0;
			o_count_pin <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			if (phase_reg == 2'h3) begin
				o_count_pin <= ~o_count_pin;
			end
		end
	end

	// Free divider for the oscillator and the sixteen-cycle match pulse
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			match_reg <= 4'h0;
		end else begin
			match_reg <= match_reg + 4'h1;
		end
	end

	// Levels requested by the bench; match pulse one cycle long
	assign o_secondary_oscillator = match_reg[1];
	assign o_period_match = i_levels[1] & (match_reg == 4'hF);
	assign o_gate_pin = i_levels[0];
	assign o_comp1 = i_levels[2];
	assign o_comp2 = i_levels[3];
endmodule : timer_far_side
